/* hw/wdt_regs_pkg.sv */
/*
 * constants, field positions and carrier types of the watchdog control block.
 * assumes a single mclk domain; the watchdog tick clock arrives as a plain pin.
 */
// ----------------------------------------------------------------------------
// Functional notes
// R01: 8, 16, 32-bit and lane accesses accepted
// R02: configuration and offset writable only while disabled
// R03: run lock set-only, cleared by power-on
// R04: run lock freezes control, configuration, offset registers
// R05: without lock, enable bit alone starts/stops
// R06: enable writable only while run lock clear
// R07: enable reads back at once, pending until synchronized
// R08: window select chooses normal or windowed mode
// R09: control registers load from boot row
// R10: shut interval code gives closed window length
// R11: timeout code gives period or open window
// R12: warn delay code gives early warning time
// R13: control/configuration writes synchronized, guard-protectable
// R14: lock and enable exempt from enable protection
// R15: enable-clear write one disables warning interrupt
// R16: key 0xa5 restarts, other value resets
// R17: restart inside closed window resets system
// R18: enable-set write one enables warning interrupt
// R19: warning flag set by event, write-one clears
// R20: counter restarts on enable and valid restart
// ----------------------------------------------------------------------------
package wdt_regs_pkg;

   // ------------------------------------------------------------------------
   // register byte offsets and fields
   // ------------------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CFG = 4'h1;
   localparam logic [3:0] OFS_EW = 4'h2;
   localparam logic [3:0] OFS_IECLR = 4'h4;
   localparam logic [3:0] OFS_IESET = 4'h5;
   localparam logic [3:0] OFS_FLAG = 4'h6;
   localparam logic [3:0] OFS_STAT = 4'h7;
   localparam logic [3:0] OFS_KEY = 4'h8;

   localparam int LOCK_BIT = 7;
   localparam int WEN_BIT = 2;
   localparam int EN_BIT = 1;
   localparam int PEND_BIT = 7;
   localparam int EW_BIT = 0;
   localparam logic [7:0] CTRL_MASK = 8'h86;
   localparam logic [7:0] EW_MASK = 8'h0f;

   // ------------------------------------------------------------------------
   // values and counts
   // ------------------------------------------------------------------------
   localparam logic IE_RESET = 1'h0;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic [7:0] RESTART_KEY = 8'ha5;
   localparam logic [3:0] CODE_MAX = 4'hb;
   localparam int CNT_W = 17;
   localparam logic [16:0] BASE_CYCLES = 17'h00008;
   localparam logic [16:0] MAX_CYCLES = 17'h04000;
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   // bus request carrier
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
      logic rd;
   } reg_req_s;

   // boot configuration row image
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cfg;
      logic [7:0] ew;
   } boot_row_s;

endpackage : wdt_regs_pkg

/* hw/wdt_ctrl.sv */
/*
 * watchdog register block with tick counter, early warning and system reset.
 * assumes boot row image stable during reset, same-clock register master,
 * and the watchdog generic clock arriving asynchronously on gen_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module wdt_ctrl (
   input wire logic mclk,                          // 50 mhz system clock
   input wire logic reset_n,                       // power-on reset, sync
   input wire logic ce,                            // clock enable
   input wire wdt_regs_pkg::reg_req_s req,         // register request
   output logic [31:0] rdata,                      // read data, cycle after
   input wire wdt_regs_pkg::boot_row_s boot,       // boot_config_row image
   input wire logic access_guard,                  // external write protect
   input wire logic gen_clk,                       // watchdog_gen_clock pin
   output logic sys_reset,                         // system reset pulse
   output logic early_warn_irq                     // early warning request
);

   // ------------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------------
   function automatic logic lane_wr(input wdt_regs_pkg::reg_req_s r,
                                    input logic [3:0] ofs);
      lane_wr = r.wr && (r.addr[3:2] == ofs[3:2]) && r.be[ofs[1:0]]; // [R01]
   endfunction : lane_wr

   function automatic logic [7:0] lane_byte(input wdt_regs_pkg::reg_req_s r,
                                            input logic [3:0] ofs);
      lane_byte = r.wdata[{ofs[1:0], 3'h0} +: 8];
   endfunction : lane_byte

   // reserved codes clamp to the longest interval
   function automatic logic [16:0] code_cycles(input logic [3:0] code);
      if (code > wdt_regs_pkg::CODE_MAX) begin
         code_cycles = wdt_regs_pkg::MAX_CYCLES;
      end else begin
         code_cycles = wdt_regs_pkg::BASE_CYCLES << code; // [R10] [R11] [R12]
      end
   endfunction : code_cycles

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [7:0] cfg_ff, nxt_cfg;
   logic [7:0] ew_ff, nxt_ew;
   logic ie_ff, nxt_ie;
   logic flag_ff, nxt_flag;
   logic pend_ff, nxt_pend;
   logic [1:0] sync_cnt_ff, nxt_sync_cnt;
   logic run_eff_ff, nxt_run_eff;
   logic win_eff_ff, nxt_win_eff;
   logic [7:0] cfg_eff_ff, nxt_cfg_eff;
   logic act_q_ff, nxt_act_q;
   logic [wdt_regs_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic rst_ff, nxt_rst;
   logic [31:0] rdata_ff, nxt_rdata;
   logic gs1_ff, gs2_ff, gs3_ff;

   logic tick, lock, active, restart, apply;
   logic wr_ctrl, wr_cfg, wr_ew, wr_ieclr, wr_ieset, wr_flag, wr_key;
   logic good_key, bad_key, early, timeout, ew_hit;
   logic [16:0] closed, open_len, limit, ew_at, cnt_inc;

   // ------------------------------------------------------------------------
   // gen clock crossing: two flops, then an edge detector on the second
   // ------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         gs1_ff <= 1'h0;
         gs2_ff <= 1'h0;
         gs3_ff <= 1'h0;
      end else if (ce) begin
         gs1_ff <= gen_clk;
         gs2_ff <= gs1_ff;
         gs3_ff <= gs2_ff;
      end
   end

   assign tick = gs2_ff && !gs3_ff;

   // ------------------------------------------------------------------------
   // write qualification
   // ------------------------------------------------------------------------
   // lock freezes ctrl; cfg and offset also need the dog stopped
   always_comb begin
      lock = ctrl_ff[wdt_regs_pkg::LOCK_BIT];
      active = lock || run_eff_ff; // [R05]
      wr_ctrl = lane_wr(req, wdt_regs_pkg::OFS_CTRL) && !access_guard && !lock; // [R04] [R06]
      wr_cfg = lane_wr(req, wdt_regs_pkg::OFS_CFG) && !access_guard && !lock
               && !ctrl_ff[wdt_regs_pkg::EN_BIT] && !run_eff_ff; // [R02] [R04] [R13]
      wr_ew = lane_wr(req, wdt_regs_pkg::OFS_EW) && !access_guard && !lock
              && !ctrl_ff[wdt_regs_pkg::EN_BIT] && !run_eff_ff; // [R02] [R04]
      wr_ieclr = lane_wr(req, wdt_regs_pkg::OFS_IECLR) && !access_guard;
      wr_ieset = lane_wr(req, wdt_regs_pkg::OFS_IESET) && !access_guard;
      wr_flag = lane_wr(req, wdt_regs_pkg::OFS_FLAG);
      wr_key = lane_wr(req, wdt_regs_pkg::OFS_KEY) && !access_guard;
   end

   // ------------------------------------------------------------------------
   // software registers and synchronizer handshake
   // ------------------------------------------------------------------------
   // a write during a pending sync restarts it; the slave never stalls
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_cfg = cfg_ff;
      nxt_ew = ew_ff;
      if (wr_ctrl) begin
         nxt_ctrl[wdt_regs_pkg::LOCK_BIT] = lock
            | lane_byte(req, wdt_regs_pkg::OFS_CTRL)[wdt_regs_pkg::LOCK_BIT]; // [R03] [R14]
         nxt_ctrl[wdt_regs_pkg::WEN_BIT] =
            lane_byte(req, wdt_regs_pkg::OFS_CTRL)[wdt_regs_pkg::WEN_BIT]; // [R08]
         nxt_ctrl[wdt_regs_pkg::EN_BIT] =
            lane_byte(req, wdt_regs_pkg::OFS_CTRL)[wdt_regs_pkg::EN_BIT]; // [R07] [R14]
      end
      if (wr_cfg) begin
         nxt_cfg = lane_byte(req, wdt_regs_pkg::OFS_CFG);
      end
      if (wr_ew) begin
         nxt_ew = lane_byte(req, wdt_regs_pkg::OFS_EW) & wdt_regs_pkg::EW_MASK;
      end
      apply = pend_ff && tick && (sync_cnt_ff == wdt_regs_pkg::SYNC_TICKS - 2'h1)
              && !(wr_ctrl || wr_cfg);
      nxt_pend = pend_ff;
      nxt_sync_cnt = sync_cnt_ff;
      if (wr_ctrl || wr_cfg) begin
         nxt_pend = 1'h1; // [R07] [R13]
         nxt_sync_cnt = 2'h0;
      end else if (apply) begin
         nxt_pend = 1'h0; // [R07]
         nxt_sync_cnt = 2'h0;
      end else if (pend_ff && tick) begin
         nxt_sync_cnt = sync_cnt_ff + 2'h1;
      end
      nxt_run_eff = run_eff_ff;
      nxt_win_eff = win_eff_ff;
      nxt_cfg_eff = cfg_eff_ff;
      if (apply) begin
         nxt_run_eff = ctrl_ff[wdt_regs_pkg::EN_BIT]; // [R05] [R07]
         nxt_win_eff = ctrl_ff[wdt_regs_pkg::WEN_BIT]; // [R08]
         nxt_cfg_eff = cfg_ff; // [R13]
      end
   end

   // boot row replaces fixed reset values
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_ff <= boot.ctrl & wdt_regs_pkg::CTRL_MASK; // [R09]
         cfg_ff <= boot.cfg; // [R09]
         ew_ff <= boot.ew & wdt_regs_pkg::EW_MASK; // [R09]
         run_eff_ff <= boot.ctrl[wdt_regs_pkg::EN_BIT];
         win_eff_ff <= boot.ctrl[wdt_regs_pkg::WEN_BIT];
         cfg_eff_ff <= boot.cfg;
         pend_ff <= 1'h0;
         sync_cnt_ff <= 2'h0;
      end else if (ce) begin
         ctrl_ff <= nxt_ctrl;
         cfg_ff <= nxt_cfg;
         ew_ff <= nxt_ew;
         run_eff_ff <= nxt_run_eff;
         win_eff_ff <= nxt_win_eff;
         cfg_eff_ff <= nxt_cfg_eff;
         pend_ff <= nxt_pend;
         sync_cnt_ff <= nxt_sync_cnt;
      end
   end

   // ------------------------------------------------------------------------
   // tick counter, restart key, early warning
   // ------------------------------------------------------------------------
   // windowed: closed then open interval; warning at the window opening
   always_comb begin
      closed = win_eff_ff ? code_cycles(cfg_eff_ff[7:4]) : 17'h00000; // [R10]
      open_len = code_cycles(cfg_eff_ff[3:0]); // [R11]
      limit = closed + open_len;
      ew_at = win_eff_ff ? closed : code_cycles(ew_ff[3:0]); // [R12]
      cnt_inc = cnt_ff + 17'h00001;
      restart = active && !act_q_ff;
      good_key = wr_key && (lane_byte(req, wdt_regs_pkg::OFS_KEY) == wdt_regs_pkg::RESTART_KEY);
      bad_key = wr_key && !good_key; // [R16]
      early = good_key && active && win_eff_ff && (cnt_ff < closed); // [R17]
      timeout = active && tick && !good_key && (cnt_inc >= limit);
      ew_hit = active && tick && !good_key && (cnt_inc == ew_at) && (ew_at < limit);
      nxt_act_q = active;
      nxt_rst = bad_key || early || timeout;
      if (!active || restart || good_key || nxt_rst) begin
         nxt_cnt = '0; // [R20] [R16]
      end else if (tick) begin
         nxt_cnt = cnt_inc;
      end else begin
         nxt_cnt = cnt_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         act_q_ff <= 1'h0;
         cnt_ff <= '0;
         rst_ff <= 1'h0;
      end else if (ce) begin
         act_q_ff <= nxt_act_q;
         cnt_ff <= nxt_cnt;
         rst_ff <= nxt_rst;
      end
   end

   assign sys_reset = rst_ff;

   // ------------------------------------------------------------------------
   // interrupt enable and flag
   // ------------------------------------------------------------------------
   // set beats clear for both the enable and the flag
   always_comb begin
      nxt_ie = ie_ff;
      if (wr_ieset && lane_byte(req, wdt_regs_pkg::OFS_IESET)[wdt_regs_pkg::EW_BIT]) begin
         nxt_ie = 1'h1; // [R18]
      end else if (wr_ieclr && lane_byte(req, wdt_regs_pkg::OFS_IECLR)[wdt_regs_pkg::EW_BIT]) begin
         nxt_ie = 1'h0; // [R15]
      end
      nxt_flag = ew_hit || (flag_ff && !(wr_flag
                 && lane_byte(req, wdt_regs_pkg::OFS_FLAG)[wdt_regs_pkg::EW_BIT])); // [R19]
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ie_ff <= wdt_regs_pkg::IE_RESET;
         flag_ff <= wdt_regs_pkg::FLAG_RESET;
      end else if (ce) begin
         ie_ff <= nxt_ie;
         flag_ff <= nxt_flag;
      end
   end

   assign early_warn_irq = ie_ff && flag_ff;

   // ------------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------------
   // data stands one cycle only, zero otherwise; key and gaps read zero
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (!req.rd) begin
         nxt_rdata = 32'h00000000;
      end else if (req.addr[3:2] == wdt_regs_pkg::OFS_CTRL[3:2]) begin
         nxt_rdata = {8'h00, ew_ff, cfg_ff, ctrl_ff}; // [R01]
      end else if (req.addr[3:2] == wdt_regs_pkg::OFS_STAT[3:2]) begin
         nxt_rdata = {pend_ff, 7'h00, 7'h00, flag_ff, 7'h00, ie_ff, 7'h00, ie_ff}; // [R15]
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdata_ff <= 32'h00000000;
      end else if (ce) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   lock_sticky_a: assert property (lock |=> lock) // [R03]
      else $error("run lock dropped");
   lock_freeze_a: assert property (lock && ce |=> $stable(cfg_ff) && $stable(ctrl_ff)) // [R04]
      else $error("locked register changed");
   enprot_cfg_a: assert property (ce && ctrl_ff[wdt_regs_pkg::EN_BIT]
                                  |=> $stable(cfg_ff) && $stable(ew_ff)) // [R02]
      else $error("protected write took effect");
   readback_a: assert property (ce && wr_ctrl |=> ctrl_ff[wdt_regs_pkg::EN_BIT]
                                == $past(req.wdata[wdt_regs_pkg::EN_BIT])) // [R07]
      else $error("enable readback wrong");
   pend_set_a: assert property (ce && (wr_ctrl || wr_cfg) |=> pend_ff) // [R07]
      else $error("pending not set");
   bad_key_a: assert property (ce && bad_key |=> sys_reset) // [R16]
      else $error("bad key gave no reset");
   closed_win_a: assert property (ce && good_key && active && win_eff_ff
                                  && cnt_ff < closed |=> sys_reset) // [R17]
      else $error("early restart not punished");
   key_restart_a: assert property (ce && good_key |=> cnt_ff == '0) // [R20]
      else $error("counter not restarted");
   ie_clear_a: assert property (ce && wr_ieclr && req.wdata[0]
                                && !(wr_ieset && req.wdata[8]) |=> !ie_ff) // [R15]
      else $error("enable clear ignored");
   flag_w1c_a: assert property (ce && wr_flag && req.wdata[16] && !ew_hit |=> !flag_ff) // [R19]
      else $error("flag not cleared");
   rd_window_a: assert property (!$past(req.rd) |-> rdata == 32'h00000000) // [R01]
      else $error("read data outside its cycle");

   // bounded forms only: each scenario is caught in the cycle it completes
   timeout_c: cover property (active && !win_eff_ff && timeout);
   window_c: cover property (win_eff_ff && ew_hit);
   sync_c: cover property (pend_ff ##1 !pend_ff);

endmodule : wdt_ctrl
`default_nettype wire

/* tb/watchdog_control_registers_tb_top.sv */
/*
 * self-checking bench for the watchdog register block, one task per scenario.
 * assumes wdt_regs_pkg and wdt_ctrl are compiled first; the tick pin is
 * driven from mclk edges, slow enough for the two-flop synchronizer.
 */
`timescale 1ns/100ps
`default_nettype none
module watchdog_control_registers_tb_top;
   // -------------------------------------------------------------------------
   // stimulus and observation signals
   // -------------------------------------------------------------------------
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   wdt_regs_pkg::reg_req_s req = '0;
   wdt_regs_pkg::boot_row_s boot = '{ctrl: 8'h04, cfg: 8'h21, ew: 8'h03};
   logic access_guard = 1'b0;
   logic gen_clk = 1'b0;
   logic [31:0] rdata;
   logic sys_reset;
   logic early_warn_irq;
   int n_fail = 0;
   int samples_checked = 0;
   int ticks = 0;
   int rst_seen = 0;
   int rst_tick = 0;
   int irq_tick = 0;

   // 50 mhz clock
   always #10 mclk = ~mclk;

   wdt_ctrl dut (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .req(req),
      .rdata(rdata),
      .boot(boot),
      .access_guard(access_guard),
      .gen_clk(gen_clk),
      .sys_reset(sys_reset),
      .early_warn_irq(early_warn_irq)
   );

   // record reset pulses and the tick at which the warning first shows
   always @(posedge mclk) begin
      if (sys_reset === 1'b1) begin
         rst_seen <= rst_seen + 1;
         rst_tick <= ticks;
      end
      if (early_warn_irq === 1'b1 && irq_tick == 0) begin
         irq_tick <= ticks;
      end
   end

   // -------------------------------------------------------------------------
   // shared bus, tick and compare tasks
   // -------------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge mclk);
      req.addr <= a;
      req.be <= be;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample just then
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd

   // ticks are counted at the rising edge; 8 mclk per tick clears the sync
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk);
         gen_clk <= 1'b1;
         ticks <= ticks + 1;
         repeat (4) @(posedge mclk);
         gen_clk <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask : tick

   task automatic key(input logic [7:0] k, input int exp_pulses);
      rst_seen = 0;
      wr(4'h8, 4'h1, {24'h000000, k});
      repeat (3) @(posedge mclk);
      check(32'(rst_seen), 32'(exp_pulses));
   endtask : key

   // -------------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------------
   task automatic s_boot_and_guard;
      rd(4'h0, 32'h0003_2104);
      rd(4'h4, 32'h0000_0000);
      access_guard <= 1'b1;
      wr(4'h0, 4'h6, 32'h0000_1100);
      rd(4'h0, 32'h0003_2104);
      access_guard <= 1'b0;
      wr(4'h0, 4'h6, 32'h0000_0100);
      rd(4'h0, 32'h0000_0104);
      tick(3);
      wr(4'h4, 4'h2, 32'h0000_0100);
      rd(4'h4, 32'h0000_0101);
   endtask : s_boot_and_guard

   task automatic s_enable_and_period;
      wr(4'h0, 4'h1, 32'h0000_0002);
      rd(4'h4, 32'h8000_0101);
      rd(4'h0, 32'h0000_0102);
      tick(3);
      rd(4'h4, 32'h0000_0101);
      key(8'ha5, 0);
      ticks = 0;
      irq_tick = 0;
      tick(20);
      check(32'(irq_tick), 32'd8);
      check(32'(rst_tick), 32'd16);
      check(32'(rst_seen), 32'd1);
   endtask : s_enable_and_period

   task automatic s_running_writes;
      wr(4'h0, 4'h6, 32'h0055_5500);
      rd(4'h0, 32'h0000_0102);
      wr(4'h4, 4'h1, 32'h0000_0000);
      rd(4'h4, 32'h0001_0101);
      wr(4'h4, 4'h1, 32'h0000_0001);
      rd(4'h4, 32'h0001_0000);
      check({31'h0, early_warn_irq}, 32'h0);
      wr(4'h4, 4'h4, 32'h0000_0000);
      rd(4'h4, 32'h0001_0000);
      wr(4'h4, 4'h4, 32'h0001_0000);
      rd(4'h4, 32'h0000_0000);
   endtask : s_running_writes

   task automatic s_bad_key_and_window;
      wr(4'h0, 4'h1, 32'h0000_0000);
      tick(3);
      key(8'h5a, 1);
      wr(4'h0, 4'h2, 32'h0000_0000);
      wr(4'h0, 4'h1, 32'h0000_0006);
      tick(3);
      key(8'ha5, 1);
      tick(10);
      key(8'ha5, 0);
   endtask : s_bad_key_and_window

   // lock cannot be undone short of power-on, so it runs last
   task automatic s_lock;
      wr(4'h0, 4'h1, 32'h0000_0086);
      wr(4'h0, 4'h7, 32'h0011_0100);
      rd(4'h0, 32'h0000_0086);
   endtask : s_lock

   // -------------------------------------------------------------------------
   // run control
   // -------------------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // all scenarios take well under a thousand cycles; allow five thousand
   initial begin
      #(20 * 5000);
      n_fail++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      s_boot_and_guard();
      s_enable_and_period();
      s_running_writes();
      s_bad_key_and_window();
      s_lock();
      stop_test();
   end
endmodule : watchdog_control_registers_tb_top
`default_nettype wire
